// >>> verilog/imdu_pkg.sv
// package: register map, field layout and timing of the integer multiply/divide unit
package imdu_pkg;
    // ==========================================
    // register indices; the ahb-lite byte address is four times the index
    localparam logic [15:0] IMDU_ADDR_CLK_GATES = 16'hff16;
    localparam logic [15:0] IMDU_ADDR_SRC_LO    = 16'hff70;
    localparam logic [15:0] IMDU_ADDR_SRC_HI    = 16'hff71;
    localparam logic [15:0] IMDU_ADDR_RLO_LO    = 16'hff72;
    localparam logic [15:0] IMDU_ADDR_RLO_HI    = 16'hff73;
    localparam logic [15:0] IMDU_ADDR_RHI_LO    = 16'hff74;
    localparam logic [15:0] IMDU_ADDR_RHI_HI    = 16'hff75;
    localparam logic [15:0] IMDU_ADDR_MODE      = 16'hff76;
    // ==========================================
    // field positions
    localparam int IMDU_BIT_GATE = 3;
    localparam int IMDU_BIT_BUSY = 0;
    localparam int IMDU_BIT_ZERO = 1;
    localparam int IMDU_BIT_OVF  = 2;
    localparam int IMDU_BIT_NEG  = 3;
    // ==========================================
    // timing: 10 cpu clock cycles per operation
    localparam int          IMDU_OP_CYCLES = 10;
    localparam logic [3:0]  IMDU_OP_LAST   = 4'(IMDU_OP_CYCLES - 1);
    localparam logic [3:0]  IMDU_RST_CNT   = 4'h0;
    localparam logic [3:0]  IMDU_RST_NIB   = 4'h0;
    // ==========================================
    // ahb-lite constants
    localparam logic [1:0]  IMDU_HTRANS_NONSEQ = 2'h2;
    localparam logic        IMDU_HRESP_OKAY    = 1'b0;

    typedef enum logic [1:0] {
        IMDU_IDLE = 2'b00,
        IMDU_RUN  = 2'b01
    } imdu_state_t;

    typedef struct packed {
        logic       neg;
        logic       ovf;
        logic       zero;
        logic       busy;
    } imdu_flags_t;

    // ahb request carrier
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [31:0] hwdata;
    } imdu_ahb_req_t;

    typedef struct packed {
        imdu_state_t st;
        logic [3:0]  cnt;
        logic        gate;
        logic [7:0]  src;
        logic [7:0]  rlo;
        logic [7:0]  rhi;
        logic        div_mode;
        logic [15:0] opa;
        logic [7:0]  opb;
        imdu_flags_t flags;
        logic        ph_valid;
        logic        ph_write;
        logic [15:0] ph_addr;
        logic [31:0] hrdata;
    } imdu_state_reg_t;
endpackage

// >>> verilog/imdu_top.sv
// integer multiply/divide unit with an ahb-lite register slave
//
// Overview of operation
// - clock-gate bit enables the unit's clock when one; readable; cleared at reset.
// - gated clock is the cpu operating clock chosen by the clock manager.
// - source operand: low nibble at one address, high at next; holds value.
// - source and result bytes are undefined after reset; never relied upon.
// - result low byte sampled at start; loaded with product low or quotient.
// - division overflow leaves both result bytes holding the dividend.
// - multiply ignores result high byte input; writes product high byte there.
// - divide samples high byte as dividend top; loads remainder when no overflow.
// - result and flags update ten cpu cycles after the mode write.
// - a mode write while idle with the gate on starts: one divides, zero multiplies.
// - mode bit reads one while running, zero when done; reset clears it.
// - zero flag shows a zero product, or a zero quotient low byte after divide; read only; reset clears it.
// - overflow flag shows division overflow; cleared after multiply; read only.
// - negative flag is product msb after multiply, quotient low byte msb after divide; read only; reset clears it.
// - multiply: negative is high byte msb; zero only when product is zero.
// - divide: negative is quotient low byte msb; zero only when quotient low byte zero.
// - divide overflow set exactly when quotient exceeds eight bits.
// - operands are unsigned: 8x8 multiply, 16/8 divide.
`timescale 1ns/1ns
`default_nettype none
module imdu_top (
    input  wire logic                   i_clk,        // cpu operating clock, 125 mhz
    input  wire logic                   i_resetn,     // synchronous reset, active low
    input  wire imdu_pkg::imdu_ahb_req_t i_ahb,       // ahb-lite request signals
    output logic                        o_hreadyout,  // slave ready
    output logic                        o_hresp,      // always okay
    output logic [31:0]                 o_hrdata,     // read data
    output logic                        o_busy,       // operation in progress
    output logic                        o_clk_gate_en // gate enable for the unit clock
);
    import imdu_pkg::*;

    imdu_state_reg_t r;
    imdu_state_reg_t next_r;

    // ==========================================
    // arithmetic, evaluated on the latched operands
    logic [15:0] prod;
    logic [15:0] quot;
    logic [7:0]  rem;
    logic        div_ovf;
    logic        addr_ok;
    logic        wr_en;
    logic        op_done;
    logic [3:0]  wnib;
    logic [3:0]  rnib;
    logic        rd_acc;
    logic        start_ok;

    always_comb begin
        prod    = r.opa[7:0] * r.opb;
        // divide by zero reports overflow; quotient would not fit anyway
        if (r.opb == 8'h00) begin
            quot = 16'hffff;
            rem  = r.opa[7:0];
        end else begin
            quot = r.opa / {8'h00, r.opb};
            rem  = 8'(r.opa % {8'h00, r.opb});
        end
        div_ovf = (quot[15:8] != 8'h00);
    end

    // ==========================================
    // register access
    always_comb begin
        addr_ok = (r.ph_addr >= IMDU_ADDR_SRC_LO && r.ph_addr <= IMDU_ADDR_MODE)
               || (r.ph_addr == IMDU_ADDR_CLK_GATES);
        wr_en   = r.ph_valid && r.ph_write;
        op_done = (r.st == IMDU_RUN) && (r.cnt == IMDU_OP_LAST);
        rd_acc  = r.ph_valid && !r.ph_write;
        start_ok = wr_en && (r.ph_addr == IMDU_ADDR_MODE) && (r.st == IMDU_IDLE) && r.gate;
        wnib    = i_ahb.hwdata[3:0];
        case (r.ph_addr)
            IMDU_ADDR_CLK_GATES: rnib = {r.gate, 3'h0};
            IMDU_ADDR_SRC_LO:    rnib = r.src[3:0];
            IMDU_ADDR_SRC_HI:    rnib = r.src[7:4];
            IMDU_ADDR_RLO_LO:    rnib = r.rlo[3:0];
            IMDU_ADDR_RLO_HI:    rnib = r.rlo[7:4];
            IMDU_ADDR_RHI_LO:    rnib = r.rhi[3:0];
            IMDU_ADDR_RHI_HI:    rnib = r.rhi[7:4];
            IMDU_ADDR_MODE:      rnib = {r.flags.neg, r.flags.ovf, r.flags.zero, r.flags.busy};
            default:             rnib = 4'h0;
        endcase
    end

    always_comb begin
        next_r = r;
        // address phase capture; reads get one wait state, writes none
        next_r.ph_valid = i_ahb.hsel && i_ahb.hready && (i_ahb.htrans == IMDU_HTRANS_NONSEQ);
        next_r.ph_write = i_ahb.hwrite;
        next_r.ph_addr  = i_ahb.haddr[17:2]; // word index
        // read data registered for the following cycle's use
        next_r.hrdata   = {28'h0000000, rnib};

        if (wr_en) begin
            case (r.ph_addr)
                IMDU_ADDR_CLK_GATES: next_r.gate = wnib[IMDU_BIT_GATE];
                IMDU_ADDR_SRC_LO:    next_r.src[3:0] = wnib;
                IMDU_ADDR_SRC_HI:    next_r.src[7:4] = wnib;
                IMDU_ADDR_RLO_LO:    next_r.rlo[3:0] = wnib;
                IMDU_ADDR_RLO_HI:    next_r.rlo[7:4] = wnib;
                IMDU_ADDR_RHI_LO:    next_r.rhi[3:0] = wnib;
                IMDU_ADDR_RHI_HI:    next_r.rhi[7:4] = wnib;
                default:             next_r.gate = r.gate;
            endcase
        end

        case (r.st)
            IMDU_IDLE: begin
                // a start with the clock gated off does nothing: no clock reaches the unit
                if (start_ok) begin
                    next_r.st         = IMDU_RUN;
                    next_r.cnt        = 4'h1;
                    next_r.div_mode   = wnib[IMDU_BIT_BUSY];
                    next_r.flags.busy = 1'b1;
                    // dividend high byte is ignored in multiply mode
                    next_r.opa = wnib[IMDU_BIT_BUSY] ? {r.rhi, r.rlo}
                                                     : {8'h00, r.rlo};
                    next_r.opb = r.src;
                end
            end
            IMDU_RUN: begin
                // counting pauses while the gate is closed, as the clock would
                if (r.gate) begin
                    next_r.cnt = r.cnt + 4'h1;
                end
                if (op_done && r.gate) begin
                    next_r.st         = IMDU_IDLE;
                    next_r.cnt        = IMDU_RST_CNT;
                    next_r.flags.busy = 1'b0;
                    if (!r.div_mode) begin
                        next_r.rlo        = prod[7:0];
                        next_r.rhi        = prod[15:8];
                        next_r.flags.neg  = prod[15];
                        next_r.flags.zero = (prod == 16'h0000);
                        next_r.flags.ovf  = 1'b0;
                    end else begin
                        next_r.flags.ovf = div_ovf;
                        if (!div_ovf) begin
                            next_r.rlo = quot[7:0];
                            next_r.rhi = rem;
                        end else begin
                            next_r.rlo = r.opa[7:0];
                            next_r.rhi = r.opa[15:8];
                        end
                        // flags follow the true quotient, also when it overflowed
                        next_r.flags.neg  = quot[7];
                        next_r.flags.zero = (quot[7:0] == 8'h00);
                    end
                end
            end
            default: begin
                next_r.st = IMDU_IDLE;
            end
        endcase
    end

    // ==========================================
    // state register; operands and result bytes keep no reset value
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            r.st       <= IMDU_IDLE;
            r.cnt      <= IMDU_RST_CNT;
            r.gate     <= 1'b0;
            r.flags    <= '0;
            r.div_mode <= 1'b0;
            r.ph_valid <= 1'b0;
            r.ph_write <= 1'b0;
            r.ph_addr  <= 16'h0000;
            r.hrdata   <= 32'h00000000;
        end else begin
            r.st       <= next_r.st;
            r.cnt      <= next_r.cnt;
            r.gate     <= next_r.gate;
            r.flags    <= next_r.flags;
            r.div_mode <= next_r.div_mode;
            r.ph_valid <= next_r.ph_valid;
            r.ph_write <= next_r.ph_write;
            r.ph_addr  <= next_r.ph_addr;
            r.hrdata   <= next_r.hrdata;
        end
        r.src <= next_r.src;
        r.rlo <= next_r.rlo;
        r.rhi <= next_r.rhi;
        r.opa <= next_r.opa;
        r.opb <= next_r.opb;
    end

    // outputs: a read gets one wait state, as the read mux is registered from
    // the latched address and must stand before the data phase ends
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_hreadyout   <= 1'b1;
            o_hresp       <= IMDU_HRESP_OKAY;
            o_busy        <= 1'b0;
            o_clk_gate_en <= 1'b0;
        end else begin
            o_hreadyout   <= !(next_r.ph_valid && !next_r.ph_write);
            o_hresp       <= IMDU_HRESP_OKAY;
            o_busy        <= next_r.flags.busy;
            o_clk_gate_en <= next_r.gate;
        end
    end
    assign o_hrdata = r.hrdata;

    // ==========================================
    // checks
    a_busy_len: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(r.flags.busy) && r.gate |-> r.flags.busy [*8] ##1 (r.flags.busy || !r.gate))
        else $error("busy dropped early");
    a_mul_ovf_clr: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $fell(r.flags.busy) && !r.div_mode |-> !r.flags.ovf)
        else $error("overflow after multiply");
    a_mul_zero: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $fell(r.flags.busy) && !r.div_mode |-> r.flags.zero == ({r.rhi, r.rlo} == 16'h0000))
        else $error("multiply zero flag wrong");
    a_mul_neg: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $fell(r.flags.busy) && !r.div_mode |-> r.flags.neg == r.rhi[7])
        else $error("multiply negative flag wrong");
    a_div_keep: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $fell(r.flags.busy) && r.div_mode && r.flags.ovf |-> {r.rhi, r.rlo} == r.opa)
        else $error("dividend not kept on overflow");
    a_div_neg: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $fell(r.flags.busy) && r.div_mode && !r.flags.ovf |-> r.flags.neg == r.rlo[7])
        else $error("divide negative flag wrong");
    a_mul_prod: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $fell(r.flags.busy) && !r.div_mode |-> {r.rhi, r.rlo} == r.opa[7:0] * r.opb)
        else $error("product wrong");
    a_gate_off_start: assert property (@(posedge i_clk) disable iff (!i_resetn)
        r.st == IMDU_IDLE && !r.gate |=> r.st == IMDU_IDLE)
        else $error("started while gated");
    c_mul: cover property (@(posedge i_clk) disable iff (!i_resetn)
        $fell(r.flags.busy) && !r.div_mode);
    c_div_ok: cover property (@(posedge i_clk) disable iff (!i_resetn)
        $fell(r.flags.busy) && r.div_mode && !r.flags.ovf);
    c_div_ovf: cover property (@(posedge i_clk) disable iff (!i_resetn)
        $fell(r.flags.busy) && r.div_mode && r.flags.ovf);

    // ==========================================
    // bus, register and operation checks
    a_rdy_wait: assert property (@(posedge i_clk) disable iff (!i_resetn)
        rd_acc
        |-> !o_hreadyout)
        else $error("read answered without a wait state");

    a_rdy_back: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !o_hreadyout
        |=> o_hreadyout)
        else $error("wait state too long");

    a_write_nowait: assert property (@(posedge i_clk) disable iff (!i_resetn)
        r.ph_valid && r.ph_write
        |-> o_hreadyout)
        else $error("write was stalled");

    a_unmapped: assert property (@(posedge i_clk) disable iff (!i_resetn)
        rd_acc && !addr_ok
        |=> o_hrdata == 32'h00000000)
        else $error("unmapped read not zero");

    a_gate_read: assert property (@(posedge i_clk) disable iff (!i_resetn)
        rd_acc && r.ph_addr == IMDU_ADDR_CLK_GATES
        |=> o_hrdata[3:0] == {$past(r.gate), 3'h0})
        else $error("gate bit read wrong");

    a_gate_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_en && r.ph_addr == IMDU_ADDR_CLK_GATES
        |=> r.gate == $past(wnib[IMDU_BIT_GATE]))
        else $error("gate bit not written");

    a_gate_pin: assert property (@(posedge i_clk) disable iff (!i_resetn)
        1'b1
        |-> o_clk_gate_en == r.gate)
        else $error("gate pin differs from gate bit");

    a_busy_pin: assert property (@(posedge i_clk) disable iff (!i_resetn)
        1'b1
        |-> o_busy == r.flags.busy)
        else $error("busy pin differs from busy bit");

    a_src_lo: assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_en && r.ph_addr == IMDU_ADDR_SRC_LO
        |=> r.src[3:0] == $past(wnib))
        else $error("source low nibble not written");

    a_src_hi: assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_en && r.ph_addr == IMDU_ADDR_SRC_HI
        |=> r.src[7:4] == $past(wnib))
        else $error("source high nibble not written");

    a_src_taken: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(r.flags.busy)
        |-> r.opb == r.src)
        else $error("source operand not taken at start");

    a_start_run: assert property (@(posedge i_clk) disable iff (!i_resetn)
        start_ok
        |=> r.st == IMDU_RUN && r.flags.busy)
        else $error("mode write did not start");

    a_start_mode: assert property (@(posedge i_clk) disable iff (!i_resetn)
        start_ok
        |=> r.div_mode == $past(wnib[IMDU_BIT_BUSY]))
        else $error("wrong operation selected");

    a_start_lo: assert property (@(posedge i_clk) disable iff (!i_resetn)
        start_ok
        |=> r.opa[7:0] == $past(r.rlo))
        else $error("result low byte not sampled");

    a_mul_hi_ign: assert property (@(posedge i_clk) disable iff (!i_resetn)
        start_ok && !wnib[IMDU_BIT_BUSY]
        |=> r.opa[15:8] == 8'h00)
        else $error("multiply used the high byte");

    a_div_hi: assert property (@(posedge i_clk) disable iff (!i_resetn)
        start_ok && wnib[IMDU_BIT_BUSY]
        |=> r.opa[15:8] == $past(r.rhi))
        else $error("dividend high byte not sampled");

    a_stay_run: assert property (@(posedge i_clk) disable iff (!i_resetn)
        r.st == IMDU_RUN && !op_done
        |=> r.st == IMDU_RUN)
        else $error("operation ended early");

    a_flags_ro: assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_en && r.ph_addr == IMDU_ADDR_MODE && !op_done
        |=> r.flags[3:1] == $past(r.flags[3:1]))
        else $error("flag changed by a write");

    a_busy_state: assert property (@(posedge i_clk) disable iff (!i_resetn)
        1'b1
        |-> r.flags.busy == (r.st == IMDU_RUN))
        else $error("busy bit differs from state");

    a_done_all: assert property (@(posedge i_clk) disable iff (!i_resetn)
        op_done && r.gate
        |=> !r.flags.busy && r.st == IMDU_IDLE)
        else $error("completion not taken");

    a_div_ovf: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $fell(r.flags.busy) && r.div_mode
        |-> r.flags.ovf == (r.opa[15:8] >= r.opb))
        else $error("divide overflow flag wrong");

    a_div_math: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $fell(r.flags.busy) && r.div_mode && !r.flags.ovf
        |-> 16'(r.rlo) * 16'(r.opb) + 16'(r.rhi) == r.opa && r.rhi < r.opb)
        else $error("quotient or remainder wrong");

    a_div_zero: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $fell(r.flags.busy) && r.div_mode && !r.flags.ovf
        |-> r.flags.zero == (r.rlo == 8'h00))
        else $error("divide zero flag wrong");

    a_cnt_idle: assert property (@(posedge i_clk) disable iff (!i_resetn)
        r.st == IMDU_IDLE
        |-> r.cnt == IMDU_RST_CNT)
        else $error("counter runs while idle");

    a_cnt_pause: assert property (@(posedge i_clk) disable iff (!i_resetn)
        r.st == IMDU_RUN && !r.gate
        |=> r.cnt == $past(r.cnt) && r.st == IMDU_RUN)
        else $error("counter ran with the gate closed");

    c_read_wait: cover property (@(posedge i_clk) disable iff (!i_resetn)
        !o_hreadyout);
    c_unmapped: cover property (@(posedge i_clk) disable iff (!i_resetn)
        rd_acc && !addr_ok);
endmodule
`default_nettype wire

// >>> verification/imdu_cpu_model.sv
// bus master model standing for the controlling cpu on the register bus
`timescale 1ns/1ns
`default_nettype none
module imdu_cpu_model (
    input  wire logic                i_clk,       // bus clock
    input  wire logic                i_hreadyout, // slave ready, is the bus hready
    input  wire logic [31:0]         i_hrdata,    // slave read data
    output var imdu_pkg::imdu_ahb_req_t o_ahb,    // request to the slave
    output logic                     o_rd_valid,  // one-cycle pulse with read data
    output logic [31:0]              o_rd_data    // data of the last read
);
    import imdu_pkg::*;
    imdu_ahb_req_t req = '0;
    logic [31:0]   last_q;

    initial begin
        o_rd_valid = 1'b0;
        o_rd_data = '0;
    end

    always_comb begin
        o_ahb = req;
        o_ahb.hready = i_hreadyout;
    end

    // ==========================================
    // single word transfer, held until hready
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [3:0] d);
        req.hsel <= 1'b1;
        req.haddr <= {14'h0, a, 2'b00};
        req.htrans <= IMDU_HTRANS_NONSEQ;
        req.hwrite <= wr;
        req.hsize <= 3'h2;
        do @(posedge i_clk); while (i_hreadyout !== 1'b1);
        req.hsel <= 1'b0;
        req.htrans <= 2'h0;
        req.haddr <= ~{14'h0, a, 2'b00};
        req.hwdata <= {28'h0, d};
        do @(posedge i_clk); while (i_hreadyout !== 1'b1);
        last_q = i_hrdata;
        // released data lines must not keep the old value
        req.hwdata <= ~{28'h0, d};
    endtask

    task automatic read(input logic [15:0] a);
        xfer(1'b0, a, 4'h0);
        // read data was taken at the edge that closed the data phase
        o_rd_data <= last_q;
        o_rd_valid <= 1'b1;
        @(posedge i_clk);
        o_rd_valid <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> verification/imdu_bench.sv
// self-checking bench of the integer multiply/divide unit
`timescale 1ns/1ns
`default_nettype none
module imdu_bench;
    import imdu_pkg::*;
    logic          clk;
    logic          resetn;
    imdu_ahb_req_t ahb;
    logic          hreadyout;
    logic          hresp;
    logic [31:0]   hrdata;
    logic          busy;
    logic          gate_en;
    logic          rd_valid;
    logic [31:0]   rd_data;
    logic [31:0]   exp_q[$];
    logic [24:0]   op;
    int            n_mismatch = 0;
    int            comparisons = 0;
    int            cycles = 0;
    int            seed = 47;
    // {divide, source, high byte, low byte}; high byte of a multiply is junk on purpose
    logic [24:0]   doc_ops[10] = '{25'h0645a00, 25'h0585a64, 25'h0585ac8, 25'h0a55ac8,
        25'h1641a16, 25'h164332c, 25'h1580000, 25'h1132468, 25'h1130024,
        25'h1131168};

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    imdu_top u_imdu_top (.i_clk(clk), .i_resetn(resetn), .i_ahb(ahb),
        .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata), .o_busy(busy),
        .o_clk_gate_en(gate_en));
    imdu_cpu_model u_imdu_cpu_model (.i_clk(clk), .i_hreadyout(hreadyout), .i_hrdata(hrdata),
        .o_ahb(ahb), .o_rd_valid(rd_valid), .o_rd_data(rd_data));

    // ==========================================
    // reporting and bus helpers
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [3:0] d);
        u_imdu_cpu_model.xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [15:0] a, input logic [3:0] e);
        exp_q.push_back({28'h0, e});
        u_imdu_cpu_model.read(a);
    endtask

    task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
        wr(a, d[3:0]);
        wr(a + 16'h1, d[7:4]);
    endtask

    task automatic rd_byte(input logic [15:0] a, input logic [7:0] e);
        rd(a, e[3:0]);
        rd(a + 16'h1, e[7:4]);
    endtask

    task automatic run_op(input logic [24:0] o, input logic new_src);
        logic        dv;
        logic [7:0]  s;
        logic [7:0]  hi;
        logic [7:0]  lo;
        logic [16:0] q;
        logic [15:0] res;
        logic [3:0]  fl;
        int          n;
        {dv, s, hi, lo} = o;
        if (new_src) wr_byte(IMDU_ADDR_SRC_LO, s);
        wr_byte(IMDU_ADDR_RLO_LO, lo);
        wr_byte(IMDU_ADDR_RHI_LO, hi);
        q = {1'b0, hi, lo} / s;
        if (!dv) res = lo * s;
        else if (q > 17'h0ff) res = {hi, lo};
        else res = {8'({hi, lo} % s), q[7:0]};
        if (dv) fl = {q[7], q > 17'h0ff, q[7:0] == 8'h0, 1'b0};
        else fl = {res[15], 1'b0, res == 16'h0, 1'b0};
        wr(IMDU_ADDR_MODE, {3'h0, dv});
        #1;
        check({31'h0, busy}, 32'h1, "busy after start");
        n = 0;
        // results and flags stay untouched while running
        while (busy === 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(32'(n >= IMDU_OP_CYCLES - 1 && n <= IMDU_OP_CYCLES + 1), 32'h1, "op length");
        rd_byte(IMDU_ADDR_RLO_LO, res[7:0]);
        rd_byte(IMDU_ADDR_RHI_LO, res[15:8]);
        rd(IMDU_ADDR_MODE, fl);
    endtask

    // ==========================================
    // result watcher and timeout
    always @(posedge clk) begin
        cycles++;
        if (rd_valid === 1'b1 && exp_q.size() > 0) begin
            check(rd_data, exp_q.pop_front(), "read data");
            check({31'h0, hresp}, {31'h0, IMDU_HRESP_OKAY}, "response");
        end
        if (cycles == 6000) begin
            n_mismatch++;
            $display("ERROR %0t timeout", $time);
            stop_test();
        end
    end

    initial begin
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rd(IMDU_ADDR_MODE, 4'h0);
        rd(IMDU_ADDR_CLK_GATES, 4'h0);
        wr(IMDU_ADDR_MODE, 4'h1);
        repeat (3) @(posedge clk);
        check({31'h0, busy}, 32'h0, "start with gate off");
        wr(IMDU_ADDR_CLK_GATES, 4'h8);
        rd(IMDU_ADDR_CLK_GATES, 4'h8);
        check({31'h0, gate_en}, 32'h1, "gate enable");
        $display("test reset and gate done");
        foreach (doc_ops[i]) run_op(doc_ops[i], 1'b1);
        $display("test table operations done");
        for (int i = 0; i < 12; i++) begin
            // odd passes reuse the source operand left from before
            if (i % 2 == 1) op = {op[24], op[23:16], 16'($random(seed))};
            else op = 25'($random(seed));
            if (op[23:16] == 8'h0) op[16] = 1'b1;
            run_op(op, i % 2 == 0);
        end
        $display("test random operations done");
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rd(IMDU_ADDR_MODE, 4'h0);
        rd(IMDU_ADDR_CLK_GATES, 4'h0);
        rd(16'hff77, 4'h0);
        check({31'h0, gate_en}, 32'h0, "gate after reset");
        repeat (4) @(posedge clk);
        check(exp_q.size(), 32'h0, "reads left over");
        $display("test second reset done");
        stop_test();
    end
endmodule
`default_nettype wire
